// ### verilog/dciwg_top.sv
// Purpose: Interrupt bookkeeping and register write guard of a display controller
// Assumes: Avalon-MM slave on clk; events and raw conditions come from logic on clk
// Notes: Every access answers after one wait cycle
// Operation
// - One to a clear bit clears pending
// - Test write forces pending bits set
// - Raw register shows present conditions, unmasked
// - Right key with one enables protection
// - Right key with zero disables protection
// - Wrong key leaves enable unchanged
// - Mode register key field reads zero
// - Protection covers fifteen configuration registers
// - Violation flag held until status read
// - Violation records guarded register offset
// - Status read returns then clears fields
// - Enable and disable registers set mask
// - Mask register shows unmasked sources
// - Status register shows unmasked pending sources
`include "dciwg_map.svh"
module dciwg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Display events: one-cycle pulses and present conditions
  input wire logic [6:0] event_pulse,
  input wire logic [6:0] raw_cond,
  // Interrupt and guarded configuration out
  output logic irq,
  output logic guard_enable,
  output logic [15*32-1:0] config_words
);

  // Reset copy used by everything below
  // Raw pin is asynchronous; release must be
  // clocked so no flop leaves reset a cycle early
  logic rst_n;

  dciwg_reset_sync u_reset_sync (
    .clk(clk),
    .reset_n(reset_n),
    .rst_sync_n(rst_n)
  );

  // Guarded window decode, used by read and write paths
  // Offset is taken after the base test so
  // addresses below the base cannot wrap into it
  // Unaligned byte addresses never hit a word
  function automatic logic is_guarded(input logic [31:0] addr);
    logic [31:0] ofs;
    ofs = addr - `DCIWG_GUARDED_BASE;
    is_guarded = (addr >= `DCIWG_GUARDED_BASE) && (ofs[1:0] == 2'b00) &&
      (ofs[31:2] < 30'(`DCIWG_GUARDED_COUNT));
  endfunction : is_guarded

  // Word index inside the guarded window
  // Only meaningful when the window decode hits
  function automatic logic [3:0] guarded_index(input logic [31:0] addr);
    logic [31:0] ofs;
    ofs = addr - `DCIWG_GUARDED_BASE;
    guarded_index = ofs[5:2];
  endfunction : guarded_index

  // Bus slave state
  // One request at a time, no queueing
  dciwg_pkg::dciwg_bus_state_t bus_state; // Current answer state
  dciwg_pkg::dciwg_bus_state_t next_bus_state; // Next answer state
  logic [31:0] next_readdata; // Next read data
  logic [31:0] wdata; // Write data with byte lanes applied
  logic wr_go; // Write takes effect this edge
  logic rd_go; // Read completes this edge

  // Interrupt state
  // Bit 3 has no source and stays zero
  logic [6:0] pending; // Sticky pending bits
  logic [6:0] next_pending; // Next pending bits
  logic [6:0] mask; // One for each unmasked source
  logic [6:0] next_mask; // Next mask
  logic [6:0] irq_status; // Pending and unmasked
  logic next_irq; // Next interrupt level

  // Guarded configuration words
  // Kept here so the guard can veto a write
  logic [31:0] cfg [0:`DCIWG_GUARDED_COUNT-1]; // Storage
  logic guarded_hit; // Address falls in the window
  logic [3:0] guarded_idx; // Word index in the window

  // Guard state from the child
  logic guard_on; // Protection active
  logic viol_flag; // Violation seen since last read
  logic [15:0] viol_src; // Offset of violating write

  // Bus strobes and shared decode
  // Disabled byte lanes read as zero in commands,
  // so a mode write with byte lanes 1 to 3 not all on never carries the key
  // Strobes fire only in the answer cycle, once
  always_comb begin
    wdata = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr_go = avs_write && (bus_state == dciwg_pkg::BUS_ANSWER);
    rd_go = avs_read && (bus_state == dciwg_pkg::BUS_ANSWER);
    guarded_hit = is_guarded(avs_address);
    guarded_idx = guarded_index(avs_address);
    irq_status = pending & mask;
  end

  // Hold the master one cycle, then answer
  // Fixed single wait state keeps timing simple
  // and gives the read mux a full cycle to settle
  // A request still up after the answer starts anew
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      dciwg_pkg::BUS_IDLE: begin
        // Request seen: answer next cycle
        if (avs_read || avs_write) begin
          next_bus_state = dciwg_pkg::BUS_ANSWER;
        end
      end
      dciwg_pkg::BUS_ANSWER: begin
        // Answer given, back to idle
        next_bus_state = dciwg_pkg::BUS_IDLE;
      end
      default: begin
        // Unused code: recover to idle
        next_bus_state = dciwg_pkg::BUS_IDLE;
      end
    endcase
  end

  // Waitrequest stays high until the answer cycle
  // Combinational so an idle bus never stalls
  // Low in the answer state or while no request is up
  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && (bus_state != dciwg_pkg::BUS_ANSWER);
  end

  // Read multiplexer, captured at the first edge of a read
  // Capturing early freezes the value the master
  // sees, even if a status bit moves meanwhile
  // Data holds between reads, never back to zero
  always_comb begin
    next_readdata = avs_readdata;
    if (avs_read && (bus_state == dciwg_pkg::BUS_IDLE)) begin
      next_readdata = `DCIWG_RST_WORD;
      if (guarded_hit) begin
        next_readdata = cfg[guarded_idx];
      end else begin
        case (avs_address)
          // One per unmasked source
          `DCIWG_IRQ_MASK_ADDR: begin
            next_readdata = {25'h0, mask};
          end
          // Pending and unmasked only
          `DCIWG_IRQ_STATUS_ADDR: begin
            next_readdata = {25'h0, irq_status};
          end
          // Conditions as they stand, mask ignored
          `DCIWG_RAW_COND_ADDR: begin
            next_readdata = {25'h0, raw_cond & `DCIWG_IRQ_VALID};
          end
          // Key field always reads zero
          `DCIWG_GUARD_MODE_ADDR: begin
            next_readdata = {31'h0, guard_on};
          end
          // Flag and source as captured, cleared later
          `DCIWG_GUARD_STATUS_ADDR: begin
            next_readdata = {8'h00, viol_src, 7'h00, viol_flag};
          end
          default: begin
            // Write-only and unmapped words read zero
            next_readdata = `DCIWG_RST_WORD;
          end
        endcase
      end
    end
  end

  // Register bus state and read data
  // Only registering here; decisions live above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= dciwg_pkg::BUS_IDLE;
      avs_readdata <= `DCIWG_RST_WORD;
    end else begin
      bus_state <= next_bus_state;
      avs_readdata <= next_readdata;
    end
  end

  // Pending and mask update
  // Mask and clear writes act on the answer edge
  // Enable ors bits in, disable clears them; a zero
  // bit is a no-op in either register
  // Interrupt level is precomputed from next values
  // so it rises on the same edge as the status bit
  always_comb begin
    next_pending = pending;
    next_mask = mask;
    if (wr_go) begin
      case (avs_address)
        // Unmask the ones written
        `DCIWG_IRQ_ENABLE_ADDR: begin
          next_mask = mask | (wdata[6:0] & `DCIWG_IRQ_VALID);
        end
        // Mask the ones written
        `DCIWG_IRQ_DISABLE_ADDR: begin
          next_mask = mask & ~wdata[6:0];
        end
        // Drop the pending ones written
        `DCIWG_IRQ_CLEAR_ADDR: begin
          next_pending = pending & ~wdata[6:0];
        end
        default: begin
          // Other writes leave pending alone
          next_pending = pending;
        end
      endcase
    end
    // Hardware events and test writes set last, so they win
    next_pending = next_pending | (event_pulse & `DCIWG_IRQ_VALID);
    if (wr_go && (avs_address == `DCIWG_FORCE_SET_ADDR)) begin
      next_pending = next_pending | (wdata[6:0] & `DCIWG_IRQ_VALID);
    end
    next_irq = |(next_pending & next_mask);
  end

  // Register interrupt state
  // Interrupt level leaves from a flop, glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= `DCIWG_RST_IRQ;
      mask <= `DCIWG_RST_IRQ;
      irq <= 1'b0;
    end else begin
      pending <= next_pending;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // Guarded configuration storage, one word each
  // Disabled lanes keep their old byte here,
  // unlike command registers where they read zero
  // A refused write is logged by the guard below
  genvar gi;
  generate
    for (gi = 0; gi < `DCIWG_GUARDED_COUNT; gi = gi + 1) begin : g_cfg
      logic [31:0] next_word; // Next stored word

      // Write only while protection is off
      // Protection state is the registered one, so a
      // keyed enable takes effect from the next access
      always_comb begin
        next_word = cfg[gi];
        if (wr_go && guarded_hit && (guarded_idx == 4'(gi)) && !guard_on) begin
          next_word = (cfg[gi] & ~{{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}) | wdata;
        end
      end

      // Register the word
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg[gi] <= `DCIWG_RST_WORD;
        end else begin
          cfg[gi] <= next_word;
        end
      end

      assign config_words[gi*32 +: 32] = cfg[gi];
    end
  endgenerate

  // Key check, violation flag and source
  // Mode writes are not guarded words, so turning
  // protection off is never itself a violation
  // Status read clears only on the answer edge
  dciwg_guard u_guard (
    .clk(clk),
    .rst_n(rst_n),
    .mode_wr(wr_go && (avs_address == `DCIWG_GUARD_MODE_ADDR)),
    .mode_wdata(wdata),
    .guarded_wr(wr_go && guarded_hit),
    .guarded_src(avs_address[15:0]),
    .status_rd(rd_go && (avs_address == `DCIWG_GUARD_STATUS_ADDR)),
    .guard_on(guard_on),
    .viol_flag(viol_flag),
    .viol_src(viol_src)
  );

  // Protection state out
  // Lets the host logic show the guard in effect
  always_comb begin
    guard_enable = guard_on;
  end

endmodule : dciwg_top

// ### verilog/dciwg_map.svh
// Purpose: Offsets, field positions, reset values and key of the display irq/guard block
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, one aligned word per register
// Notes: Definitions only
`ifndef DCIWG_MAP_SVH
`define DCIWG_MAP_SVH

// Register byte addresses
`define DCIWG_IRQ_ENABLE_ADDR 32'h0050_0848
`define DCIWG_IRQ_DISABLE_ADDR 32'h0050_084C
`define DCIWG_IRQ_MASK_ADDR 32'h0050_0850
`define DCIWG_IRQ_STATUS_ADDR 32'h0050_0854
`define DCIWG_IRQ_CLEAR_ADDR 32'h0050_0858
`define DCIWG_FORCE_SET_ADDR 32'h0050_0860
`define DCIWG_RAW_COND_ADDR 32'h0050_0864
`define DCIWG_GUARD_MODE_ADDR 32'h0050_08E4
`define DCIWG_GUARD_STATUS_ADDR 32'h0050_08E8
// Guarded configuration window: base and word count
`define DCIWG_GUARDED_BASE 32'h0050_0800
`define DCIWG_GUARDED_COUNT 15

// Interrupt source bit positions
`define DCIWG_BIT_LINE 0
`define DCIWG_BIT_LAST_LINE 1
`define DCIWG_BIT_FRAME_END 2
`define DCIWG_BIT_UNDERFLOW 4
`define DCIWG_BIT_OVERWRITE 5
`define DCIWG_BIT_MEM_ERROR 6
`define DCIWG_IRQ_WIDTH 7
`define DCIWG_IRQ_VALID 7'h77

// Write guard fields
`define DCIWG_GUARD_KEY 24'h4C4344
`define DCIWG_KEY_MSB 31
`define DCIWG_KEY_LSB 8
`define DCIWG_ENABLE_BIT 0
`define DCIWG_VIOL_FLAG_BIT 0
`define DCIWG_SRC_MSB 23
`define DCIWG_SRC_LSB 8

// Reset values
`define DCIWG_RST_WORD 32'h0000_0000
`define DCIWG_RST_IRQ 7'h00
`define DCIWG_RST_SRC 16'h0000

`endif

// ### verilog/dciwg_pkg.sv
// Purpose: Types shared by the display irq/guard block
// Assumes: Numbers live in dciwg_map.svh
// Notes: Gray-coded bus answer states
package dciwg_pkg;

  // Bus slave state: idle, then one answer cycle
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } dciwg_bus_state_t;

endpackage : dciwg_pkg

// ### verilog/dciwg_reset_sync.sv
// Purpose: Release an asynchronous active-low reset through two flip-flops
// Assumes: Assert is asynchronous, release is clocked
// Notes: Flops only take constants under reset
module dciwg_reset_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic reset_n,
  // Synchronised reset
  output logic rst_sync_n
);

  logic stage1_n; // First stage, read only by the second
  logic next_stage1_n; // Next first stage
  logic next_rst_sync_n; // Next second stage

  // Shift a one in behind the release
  always_comb begin
    next_stage1_n = 1'b1;
    next_rst_sync_n = stage1_n;
  end

  // Register both stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage1_n <= next_stage1_n;
      rst_sync_n <= next_rst_sync_n;
    end
  end

endmodule : dciwg_reset_sync

// ### verilog/dciwg_guard.sv
// Purpose: Key-guarded protection enable with violation flag and source
// Assumes: Strobes are one-cycle pulses from the bus slave
// Notes: A violation in the clearing read cycle survives the clear
`include "dciwg_map.svh"
module dciwg_guard (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode register write
  input wire logic mode_wr,
  input wire logic [31:0] mode_wdata,
  // Guarded write attempt and status read
  input wire logic guarded_wr,
  input wire logic [15:0] guarded_src,
  input wire logic status_rd,
  // Guard state
  output logic guard_on,
  output logic viol_flag,
  output logic [15:0] viol_src
);

  logic next_guard_on; // Next protection enable
  logic next_viol_flag; // Next violation flag
  logic [15:0] next_viol_src; // Next violation source
  logic key_ok; // Key field matches
  logic violation; // Write attempt while protected

  // Key check and violation detect
  always_comb begin
    key_ok = (mode_wdata[`DCIWG_KEY_MSB:`DCIWG_KEY_LSB] == `DCIWG_GUARD_KEY);
    violation = guarded_wr && guard_on;
  end

  // Next guard state
  always_comb begin
    next_guard_on = guard_on;
    next_viol_flag = viol_flag;
    next_viol_src = viol_src;
    // Enable moves only with the right key
    if (mode_wr && key_ok) begin
      next_guard_on = mode_wdata[`DCIWG_ENABLE_BIT];
    end
    // Wrong key: enable untouched
    if (status_rd) begin
      next_viol_flag = 1'b0;
      next_viol_src = `DCIWG_RST_SRC;
    end
    // Set wins over the read clear
    if (violation) begin
      next_viol_flag = 1'b1;
      next_viol_src = guarded_src;
    end
  end

  // Register guard state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_on <= 1'b0;
      viol_flag <= 1'b0;
      viol_src <= `DCIWG_RST_SRC;
    end else begin
      guard_on <= next_guard_on;
      viol_flag <= next_viol_flag;
      viol_src <= next_viol_src;
    end
  end

endmodule : dciwg_guard

// ### test/dciwg_top_sva.sv
// Purpose: Port-level checks of the display irq and write guard block
// Assumes: One clock; no request while the internal reset runs
// Notes: Bound to dciwg_top after the module
`include "dciwg_map.svh"
module dciwg_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events and outputs
  input wire logic [6:0] event_pulse,
  input wire logic [6:0] raw_cond,
  input wire logic irq,
  input wire logic guard_enable,
  input wire logic [15*32-1:0] config_words
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Accesses accepted at this edge
  wire logic acc_wr = avs_write & ~avs_waitrequest;
  wire logic acc_rd = avs_read & ~avs_waitrequest;
  // Mode write carrying the right key
  wire logic key_ok = acc_wr && avs_address == `DCIWG_GUARD_MODE_ADDR && avs_byteenable == 4'hF
    && avs_writedata[31:8] == `DCIWG_GUARD_KEY;
  // Address inside the guarded window
  wire logic in_win = avs_address >= `DCIWG_GUARDED_BASE
    && avs_address < `DCIWG_GUARDED_BASE + 4 * `DCIWG_GUARDED_COUNT;
  // Causes that may raise or drop the interrupt
  wire logic up_cause = event_pulse != 7'h00 || (acc_wr && (avs_address == `DCIWG_FORCE_SET_ADDR
    || avs_address == `DCIWG_IRQ_ENABLE_ADDR));
  wire logic dn_cause = acc_wr && (avs_address == `DCIWG_IRQ_CLEAR_ADDR
    || avs_address == `DCIWG_IRQ_DISABLE_ADDR);

  bus_wait_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after exactly one wait cycle");
  bus_idle_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("wait raised while idle");
  guard_set_a: assert property (key_ok |=>
    guard_enable == $past(avs_writedata[0]))
    else $error("keyed mode write did not set protection");
  guard_hold_a: assert property ($changed(guard_enable) |-> $past(key_ok))
    else $error("protection changed without keyed write");
  key_read_a: assert property (acc_rd && avs_address == `DCIWG_GUARD_MODE_ADDR |->
    avs_readdata == {31'h0, guard_enable})
    else $error("mode read shows key bits or wrong enable");
  guard_ro_a: assert property (acc_wr && guard_enable && in_win |=>
    $stable(config_words))
    else $error("guarded word changed while protected");
  raw_show_a: assert property (acc_rd && avs_address == `DCIWG_RAW_COND_ADDR |->
    avs_readdata[31:7] == 25'h0 && (avs_readdata[6:0] & 7'h77) == ($past(raw_cond) & 7'h77))
    else $error("raw register differs from conditions");
  irq_rise_a: assert property ($rose(irq) |->
    $past(up_cause) || $past(up_cause, 2))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq) |->
    $past(dn_cause) || $past(dn_cause, 2))
    else $error("interrupt fell without clear or disable");
endmodule : dciwg_top_sva

bind dciwg_top dciwg_top_sva i_sva (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .event_pulse(event_pulse), .raw_cond(raw_cond),
  .irq(irq), .guard_enable(guard_enable), .config_words(config_words));

// ### test/test_display_ctrl_irq_and_write_guard.sv
// Purpose: Register-level test of the display irq and write guard block
// Assumes: One access at a time, all byte lanes on unless a test narrows them
// Notes: Addresses come from the map constants; expected values are written as literals
`include "dciwg_map.svh"
module test_display_ctrl_irq_and_write_guard;
  timeunit 1ns;
  timeprecision 1ps;
  // Register addresses
  localparam logic [31:0] a_en = `DCIWG_IRQ_ENABLE_ADDR;
  localparam logic [31:0] a_dis = `DCIWG_IRQ_DISABLE_ADDR;
  localparam logic [31:0] a_msk = `DCIWG_IRQ_MASK_ADDR;
  localparam logic [31:0] a_st = `DCIWG_IRQ_STATUS_ADDR;
  localparam logic [31:0] a_clr = `DCIWG_IRQ_CLEAR_ADDR;
  localparam logic [31:0] a_frc = `DCIWG_FORCE_SET_ADDR;
  localparam logic [31:0] a_md = `DCIWG_GUARD_MODE_ADDR;
  localparam logic [31:0] a_gs = `DCIWG_GUARD_STATUS_ADDR;
  localparam logic [31:0] a_cfg = `DCIWG_GUARDED_BASE;
  // Source bit positions
  localparam int srcs[6] = '{0, 1, 2, 4, 5, 6};
  // Stimulus
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] avs_address = 32'h0000_0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [6:0] event_pulse = 7'h00;
  logic [6:0] raw_cond = 7'h00;
  // Responses
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic guard_enable;
  logic [15*32-1:0] config_words;
  // Score and scratch
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] ga;

  dciwg_top i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .event_pulse(event_pulse), .raw_cond(raw_cond), .irq(irq),
    .guard_enable(guard_enable), .config_words(config_words));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // Compare one value
  task automatic cmp(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // One bus access; evt pulses in the answer cycle
  task automatic bus(input logic wr, input logic [31:0] a, d, input logic [6:0] evt,
    output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
      event_pulse <= avs_waitrequest ? evt : 7'h00;
    end while (avs_waitrequest && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Hung bus ends the run
    if (avs_waitrequest) begin
      miscompares++;
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [31:0] a, d, input logic [6:0] evt = 7'h00);
    logic [31:0] q;
    bus(1'b1, a, d, evt, q);
  endtask : wr

  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 7'h00, q);
    cmp($sformatf("read %h", a), e, q);
  endtask : rdc

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values
    rdc(a_msk, 32'h0);
    rdc(a_st, 32'h0);
    rdc(a_gs, 32'h0);
    cmp("guard reset", 32'h0, {31'h0, guard_enable});
    // Mask through enable and disable
    wr(a_en, 32'hFFFF_FFFF);
    rdc(a_msk, 32'h77);
    wr(a_dis, 32'h05);
    wr(a_en, 32'h0);
    rdc(a_msk, 32'h72);
    wr(a_en, 32'h05);
    // Each source forced, kept, cleared
    for (int i = 0; i < 6; i++) begin
      ga = 32'h1 << srcs[i];
      wr(a_frc, ga);
      rdc(a_st, ga);
      cmp("irq high", 32'h1, {31'h0, irq});
      wr(a_clr, 32'h0);
      rdc(a_st, ga);
      wr(a_clr, ga);
      rdc(a_st, 32'h0);
      cmp("irq low", 32'h0, {31'h0, irq});
    end
    wr(a_frc, 32'h0);
    rdc(a_st, 32'h0);
    // Masked source stays quiet
    wr(a_dis, 32'h77);
    wr(a_frc, 32'h40);
    rdc(a_st, 32'h0);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(a_en, 32'h40);
    rdc(a_st, 32'h40);
    // Event in the clear cycle wins
    wr(a_clr, 32'h40, 7'h40);
    rdc(a_st, 32'h40);
    wr(a_en, 32'h77);
    wr(32'h0050_0900, 32'hFFFF_FFFF, 7'h24);
    rdc(a_st, 32'h64);
    wr(a_clr, 32'h77);
    rdc(a_st, 32'h0);
    rdc(32'h0050_0900, 32'h0);
    // Raw conditions ignore the mask; the unused bit is dropped
    wr(a_dis, 32'h77);
    raw_cond <= 7'h5D;
    rdc(`DCIWG_RAW_COND_ADDR, 32'h55);
    raw_cond <= 7'h22;
    rdc(`DCIWG_RAW_COND_ADDR, 32'h22);
    // Open writes, then a wrong key
    wr(a_cfg, 32'h1234_5678);
    wr(a_cfg + 32'h38, 32'hA5A5_0001);
    wr(a_md, 32'h4C43_4501);
    rdc(a_md, 32'h0);
    cmp("word 0", 32'h1234_5678, config_words[31:0]);
    // Protection on, every guarded word refused and logged
    wr(a_md, {`DCIWG_GUARD_KEY, 8'h01});
    rdc(a_md, 32'h1);
    cmp("guard on", 32'h1, {31'h0, guard_enable});
    for (int i = 0; i < `DCIWG_GUARDED_COUNT; i++) begin
      ga = a_cfg + 32'(4 * i);
      wr(ga, 32'hFFFF_FFFF);
      wr(a_en, 32'h0);
      rdc(a_gs, {8'h00, ga[15:0], 8'h01});
      rdc(a_gs, 32'h0);
    end
    cmp("word 0", 32'h1234_5678, config_words[31:0]);
    cmp("word 14", 32'hA5A5_0001, config_words[14*32+:32]);
    // Protection off
    wr(a_md, {`DCIWG_GUARD_KEY, 8'h00});
    wr(a_cfg + 32'h38, 32'h0000_005A);
    cmp("guard off", 32'h0, {31'h0, guard_enable});
    rdc(a_gs, 32'h0);
    cmp("word 14", 32'h0000_005A, config_words[14*32+:32]);
    // Narrow lanes: no key reaches the mode register, old bytes kept
    avs_byteenable <= 4'h1;
    wr(a_md, {`DCIWG_GUARD_KEY, 8'h01});
    wr(a_cfg, 32'hFFFF_FFAA);
    avs_byteenable <= 4'hF;
    rdc(a_md, 32'h0);
    cmp("word 0", 32'h1234_56AA, config_words[31:0]);
    summarize();
  end
endmodule : test_display_ctrl_irq_and_write_guard
